// File: include/rsb_pkg.sv
package rsb_pkg;

  // core counts and strap widths
  localparam int RSB_NUM_CPU = 4;
  localparam int RSB_NUM_MAIN = 16;
  localparam int RSB_NUM_DBG = 4;
  localparam int RSB_NUM_LINK = 4;
  localparam int RSB_NUM_ETH = 2;
  localparam int RSB_DIV_W = 8;
  localparam int RSB_IP_W = 8;

  // field positions inside the debug gate vector
  localparam int RSB_DBG_UNIT = 0;
  localparam int RSB_DBG_BUS = 1;
  localparam int RSB_DBG_LINK0 = 2;

  // memory controller selection and clock ratio codes
  localparam logic RSB_MEM_SDR = 1'h0;
  localparam logic RSB_MEM_DDR = 1'h1;
  localparam logic [1:0] RSB_RATIO_1X = 2'h0;
  localparam logic [1:0] RSB_RATIO_QUARTER = 2'h1;
  localparam logic [1:0] RSB_RATIO_2X = 2'h2;

  // ethernet debug link bus codes
  localparam logic RSB_BUS_MIO = 1'h0;
  localparam logic RSB_BUS_DBG = 1'h1;

  // boot address and reset values
  localparam logic [31:0] RSB_BOOT_ADDR = 32'h0000_0000;
  localparam logic [RSB_DIV_W-1:0] RSB_DIV_RST = 8'h00;

  // sampled strap image
  typedef struct packed {
    logic dbg_en;
    logic dbg_break;
    logic mem_sel;
    logic mem_ratio;
    logic boot_present;
    logic [RSB_DIV_W-1:0] link_div;
    logic [RSB_NUM_LINK-1:0] link_rmap;
    logic dbg_rmap;
    logic [RSB_NUM_ETH-1:0] eth_bus;
    logic [RSB_IP_W-1:0] ip_low;
  } rsb_strap_t;

  // boot sequencing states of the first processor
  typedef enum logic [1:0] {
    RSB_ST_RESET,
    RSB_ST_DEBUG,
    RSB_ST_FETCH,
    RSB_ST_RUN
  } rsb_boot_t;

  localparam int RSB_STRAP_W = $bits(rsb_strap_t);

endpackage : rsb_pkg

// File: design/rsb_sync.sv
`timescale 1ns/1ns
// two flop synchroniser for a vector of pin levels
module rsb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,           // system clock
  input wire logic rst,               // async reset, high
  input wire logic [WIDTH-1:0] din,   // raw pin levels
  output logic [WIDTH-1:0] dout       // synchronised levels
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_dout;

  // next values, no logic on the first stage
  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  // register both stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule : rsb_sync

// File: design/rsb_top.sv
`timescale 1ns/1ns
// Overview of operation
// (R01) all cores clocked during power-up and reset
// (R02) after reset main cores clocked, debug gates strapped
// (R03) debug enable off gates unit, bus, links
// (R04) select strap picks sdr or ddr controller
// (R05) ratio strap picks memory clock ratio
// (R06) absent boot memory errors first fetch
// (R07) eight bit strap loads link clock divisor
// (R08) four straps enable link remote targets
// (R09) one strap enables debug remote target
// (R10) two bit strap picks ethernet debug bus
// (R11) debug bus gated forces master io bus
// (R12) debug bus chosen without debug disables link
// (R13) low gpio pins give ip address nibbles
// (R14) break plus enable puts processors in debug
// (R15) otherwise only first processor boots at start
// (R16) boot fetch error puts processor in error
// (R17) software loaded remotely, cpus started by irq controller
// (R18) synchronous reset, async for pci and tristate
// (R19) software and idle clock gating per core
// (R20) straps captured in reset, held afterwards
module rsb_top
  import rsb_pkg::*;
#(
  parameter int NUM_CPU = RSB_NUM_CPU,
  parameter int NUM_MAIN = RSB_NUM_MAIN
) (
  input wire logic clk_sys,                        // system clock, 50 MHz
  input wire logic rst,                            // system reset, high
  input wire logic debug_unit_enable_strap,        // debug unit enable pin
  input wire logic debug_break_strap,              // debug break pin
  input wire logic memory_interface_select_strap,  // 0 sdr, 1 ddr
  input wire logic memory_clock_ratio_strap,       // memory clock ratio pin
  input wire logic boot_memory_present_strap,      // boot memory fitted
  input wire logic [RSB_DIV_W-1:0] link_clock_divisor_strap, // divisor pins
  input wire logic [RSB_NUM_LINK-1:0] link_remote_target_enable_straps, // per link
  input wire logic debug_remote_target_enable_strap, // debug remote target
  input wire logic [RSB_NUM_ETH-1:0] ethernet_debug_bus_select_strap, // per eth
  input wire logic [RSB_IP_W-1:0] gpio_low,        // lowest gpio pins
  input wire logic [NUM_MAIN-1:0] sw_gate_main,    // software gate, main cores
  input wire logic [RSB_NUM_DBG-1:0] sw_gate_dbg_set, // software gate debug cores
  input wire logic [RSB_NUM_DBG-1:0] sw_gate_dbg_clr, // software ungate debug
  input wire logic [NUM_CPU-1:0] cpu_idle,         // processor idle level
  input wire logic boot_fetch_req,                 // first cpu fetch pulse
  input wire logic [NUM_CPU-1:0] cpu_start,        // irq controller start pulse
  output logic [NUM_MAIN-1:0] main_clk_en,         // main core clock enables
  output logic [RSB_NUM_DBG-1:0] dbg_clk_en,       // debug core clock enables
  output logic [NUM_CPU-1:0] cpu_clk_en,           // processor clock enables
  output logic mem_ddr_sel,                        // ddr controller owns pads
  output logic [1:0] mem_ratio,                    // memory clock ratio code
  output logic boot_present,                       // boot memory present
  output logic boot_fetch_err,                     // error answer to boot fetch
  output logic [RSB_DIV_W-1:0] link_div,           // initial link divisor
  output logic [RSB_NUM_LINK-1:0] link_rmap_en,    // link remote targets
  output logic dbg_rmap_en,                        // debug remote target
  output logic [RSB_NUM_ETH-1:0] eth_dbg_bus,      // 1 debug bus, 0 master io
  output logic [RSB_NUM_ETH-1:0] eth_dbg_en,       // ethernet debug link enable
  output logic [RSB_IP_W-1:0] eth_ip_low,          // ip address low nibbles
  output logic [NUM_CPU-1:0] cpu_debug,            // processor in debug mode
  output logic [NUM_CPU-1:0] cpu_run,              // processor executing
  output logic cpu0_error,                         // first processor error mode
  output logic [31:0] boot_addr                    // first fetch address
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  rsb_strap_t pins;
  rsb_strap_t pins_s;
  logic rst_s;
  rsb_strap_t strap;
  rsb_strap_t next_strap;

  // pack raw pins into the strap image
  always_comb begin
    pins.dbg_en = debug_unit_enable_strap;
    pins.dbg_break = debug_break_strap;
    pins.mem_sel = memory_interface_select_strap;
    pins.mem_ratio = memory_clock_ratio_strap;
    pins.boot_present = boot_memory_present_strap;
    pins.link_div = link_clock_divisor_strap;
    pins.link_rmap = link_remote_target_enable_straps;
    pins.dbg_rmap = debug_remote_target_enable_strap;
    pins.eth_bus = ethernet_debug_bus_select_strap;
    pins.ip_low = gpio_low;
  end

  rsb_sync #(
    .WIDTH(RSB_STRAP_W)
  ) u_sync_pins (
    .clk_sys(clk_sys),
    .rst(1'h0),
    .din(pins),
    .dout(pins_s)
  );

  // reset level seen by clocked logic, sampled through two flops
  rsb_sync #(
    .WIDTH(1)
  ) u_sync_rst (
    .clk_sys(clk_sys),
    .rst(1'h0),
    .din(rst),
    .dout(rst_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  // follow pins while reset stands, freeze after release
  always_comb begin
    next_strap = strap;
    if (rst || rst_s) begin
      next_strap = pins_s; // see (R20)
    end
  end

  // clocked capture, no async reset so pin levels may be loaded
  always_ff @(posedge clk_sys) begin
    strap <= next_strap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // static configuration outputs

  logic in_rst;
  logic [RSB_NUM_ETH-1:0] next_eth_bus;
  logic [RSB_NUM_ETH-1:0] next_eth_en;
  logic [RSB_NUM_DBG-1:0] dbg_reset_val;
  logic [1:0] next_ratio;

  assign in_rst = rst || rst_s;

  // decode ratio strap under the chosen controller
  function automatic logic [1:0] ratio_code(input logic ddr, input logic r);
    if (!r) begin
      ratio_code = RSB_RATIO_1X;
    end else if (ddr) begin
      ratio_code = RSB_RATIO_2X;
    end else begin
      ratio_code = RSB_RATIO_QUARTER;
    end
  endfunction : ratio_code

  // ethernet debug link routing
  always_comb begin
    for (int i = 0; i < RSB_NUM_ETH; i++) begin
      next_eth_bus[i] = strap.dbg_en ? strap.eth_bus[i] : RSB_BUS_MIO; // see (R10) see (R11)
      next_eth_en[i] = !(strap.eth_bus[i] == RSB_BUS_DBG && !strap.dbg_en); // see (R12)
    end
    next_ratio = ratio_code(strap.mem_sel, strap.mem_ratio); // see (R05)
    dbg_reset_val = {RSB_NUM_DBG{strap.dbg_en}}; // see (R02) see (R03)
  end

  // register the static outputs, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (in_rst) begin // see (R18)
      mem_ddr_sel <= RSB_MEM_SDR;
      mem_ratio <= RSB_RATIO_1X;
      boot_present <= 1'h0;
      link_div <= RSB_DIV_RST;
      link_rmap_en <= '0;
      dbg_rmap_en <= 1'h0;
      eth_dbg_bus <= '0;
      eth_dbg_en <= '0;
      eth_ip_low <= '0;
      boot_addr <= RSB_BOOT_ADDR;
    end else begin
      mem_ddr_sel <= strap.mem_sel; // see (R04)
      mem_ratio <= next_ratio;
      boot_present <= strap.boot_present; // see (R06)
      link_div <= strap.link_div; // see (R07)
      link_rmap_en <= strap.link_rmap; // see (R08)
      dbg_rmap_en <= strap.dbg_rmap; // see (R09)
      eth_dbg_bus <= next_eth_bus;
      eth_dbg_en <= next_eth_en;
      eth_ip_low <= strap.ip_low; // see (R13)
      boot_addr <= RSB_BOOT_ADDR; // see (R15)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gating

  logic [RSB_NUM_DBG-1:0] dbg_gate;
  logic [RSB_NUM_DBG-1:0] next_dbg_gate;
  logic [NUM_MAIN-1:0] next_main_en;
  logic [RSB_NUM_DBG-1:0] next_dbg_en;
  logic [NUM_CPU-1:0] next_cpu_en;

  // debug gate bits: strap reset value, then software set and clear
  always_comb begin
    next_dbg_gate = (dbg_gate | sw_gate_dbg_clr) & ~sw_gate_dbg_set; // see (R19)
    if (in_rst) begin
      next_dbg_gate = dbg_reset_val; // see (R02)
    end
  end

  // enables: everything on during reset, gated by software and processor idle afterwards
  always_comb begin
    next_main_en = ~sw_gate_main; // see (R19)
    next_dbg_en = dbg_gate;
    for (int i = 0; i < NUM_CPU; i++) begin
      next_cpu_en[i] = !cpu_idle[i] && !sw_gate_main[i]; // see (R19)
    end
    if (in_rst) begin
      next_main_en = '1; // see (R01)
      next_dbg_en = '1;
      next_cpu_en = '1;
    end
  end

  // register the gate state and enables
  always_ff @(posedge clk_sys) begin
    dbg_gate <= next_dbg_gate;
    main_clk_en <= next_main_en;
    dbg_clk_en <= next_dbg_en; // see (R03)
    cpu_clk_en <= next_cpu_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencing

  rsb_boot_t state;
  rsb_boot_t next_state;
  logic [NUM_CPU-1:0] next_cpu_debug;
  logic [NUM_CPU-1:0] next_cpu_run;
  logic next_err;
  logic next_fetch_err;

  // choose debug entry or first processor boot
  always_comb begin
    next_state = state;
    next_cpu_debug = cpu_debug;
    next_cpu_run = cpu_run | cpu_start; // see (R17)
    next_err = cpu0_error;
    next_fetch_err = 1'h0;
    unique case (state)
      RSB_ST_RESET: begin
        if (strap.dbg_en && strap.dbg_break) begin
          next_state = RSB_ST_DEBUG;
          next_cpu_debug = '1; // see (R14)
        end else begin
          next_state = RSB_ST_FETCH;
          next_cpu_run[0] = 1'h1; // see (R15)
        end
      end
      RSB_ST_DEBUG: begin
        next_cpu_debug = cpu_debug & ~cpu_start;
      end
      RSB_ST_FETCH: begin
        if (boot_fetch_req) begin
          next_state = RSB_ST_RUN;
          if (!strap.boot_present) begin
            next_fetch_err = 1'h1; // see (R06)
            next_err = 1'h1; // see (R16)
            next_cpu_run[0] = cpu_start[0];
          end
        end
      end
      RSB_ST_RUN: begin
        if (cpu_start[0]) begin
          next_err = 1'h0; // see (R17)
        end
      end
    endcase
    if (in_rst) begin
      next_state = RSB_ST_RESET;
      next_cpu_debug = '0;
      next_cpu_run = '0;
      next_err = 1'h0;
      next_fetch_err = 1'h0;
    end
  end

  // register boot state
  always_ff @(posedge clk_sys) begin
    state <= next_state;
    cpu_debug <= next_cpu_debug;
    cpu_run <= next_cpu_run;
    cpu0_error <= next_err;
    boot_fetch_err <= next_fetch_err;
  end

endmodule : rsb_top

// File: dv/rsb_board.sv
`timescale 1ns/1ns
// board strap resistors and low gpio levels seen by the block
module rsb_board
  import rsb_pkg::*;
(
  input wire rsb_strap_t image, // wanted pin levels
  output logic debug_unit_enable_strap, // debug enable
  output logic debug_break_strap, // debug break
  output logic memory_interface_select_strap, // sdr or ddr
  output logic memory_clock_ratio_strap, // ratio
  output logic boot_memory_present_strap, // boot fitted
  output logic [RSB_DIV_W-1:0] link_clock_divisor_strap, // divisor
  output logic [RSB_NUM_LINK-1:0] link_remote_target_enable_straps, // link targets
  output logic debug_remote_target_enable_strap, // debug target
  output logic [RSB_NUM_ETH-1:0] ethernet_debug_bus_select_strap, // eth bus
  output logic [RSB_IP_W-1:0] gpio_low // ip nibbles
);
  // straps are always driven, so pins simply follow the image
  assign {debug_unit_enable_strap, debug_break_strap, memory_interface_select_strap,
    memory_clock_ratio_strap, boot_memory_present_strap, link_clock_divisor_strap,
    link_remote_target_enable_straps, debug_remote_target_enable_strap,
    ethernet_debug_bus_select_strap, gpio_low} = image;
endmodule : rsb_board

// File: dv/rsb_top_assertions.sv
`timescale 1ns/1ns
// port level checks of the reset and boot block
module rsb_checker
  import rsb_pkg::*;
#(
  parameter int NUM_CPU = RSB_NUM_CPU,
  parameter int NUM_MAIN = RSB_NUM_MAIN
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [NUM_CPU-1:0] cpu_idle, // idle levels
  input wire logic boot_fetch_req, // first fetch
  input wire logic [NUM_MAIN-1:0] main_clk_en, // main enables
  input wire logic [RSB_NUM_DBG-1:0] dbg_clk_en, // debug enables
  input wire logic [NUM_CPU-1:0] cpu_clk_en, // cpu enables
  input wire logic mem_ddr_sel, // ddr owns pads
  input wire logic [1:0] mem_ratio, // ratio code
  input wire logic boot_present, // boot fitted
  input wire logic boot_fetch_err, // fetch error
  input wire logic [RSB_DIV_W-1:0] link_div, // divisor
  input wire logic [RSB_NUM_ETH-1:0] eth_dbg_bus, // eth bus
  input wire logic [RSB_NUM_ETH-1:0] eth_dbg_en, // eth enable
  input wire logic [NUM_CPU-1:0] cpu_debug, // debug mode
  input wire logic [NUM_CPU-1:0] cpu_run, // executing
  input wire logic cpu0_error // error mode
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // edges since reset release, saturating at 7
  always_comb begin
    next_cnt = (cnt == 3'h7) ? cnt : cnt + 3'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 3'h0;
    end else begin
      cnt <= next_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_clk; cnt < 3'h3 |-> &main_clk_en && &dbg_clk_en && &cpu_clk_en; endproperty
  a_rst_clk: assert property (p_rst_clk)
    else $error("clock enable low right after reset");
  property p_hold; cnt == 3'h7 |-> $stable(link_div) && $stable(mem_ddr_sel)
    && $stable(boot_present) && $stable(eth_dbg_bus); endproperty
  a_hold: assert property (p_hold)
    else $error("configuration moved after load");
  property p_ratio; cnt == 3'h7 |-> mem_ratio != 2'h3
    && mem_ratio != (mem_ddr_sel ? RSB_RATIO_QUARTER : RSB_RATIO_2X); endproperty
  a_ratio: assert property (p_ratio)
    else $error("ratio code illegal for controller");
  property p_route; cnt == 3'h7 |-> (eth_dbg_bus & ~eth_dbg_en) == '0; endproperty
  a_route: assert property (p_route)
    else $error("disabled link left on debug bus");
  property p_dbg_all; $rose(cpu_debug[0]) |-> &cpu_debug && cpu_run == '0; endproperty
  a_dbg_all: assert property (p_dbg_all)
    else $error("not all processors in debug");
  property p_boot_one; $rose(cpu_run[0]) && cnt != 3'h7
    |-> cpu_run[NUM_CPU-1:1] == '0 && cpu_debug == '0; endproperty
  a_boot_one: assert property (p_boot_one)
    else $error("more than first processor started");
  property p_fetch; boot_fetch_req && cpu_run[0] && !cpu0_error && !boot_present
    |=> boot_fetch_err && cpu0_error && !cpu_run[0]; endproperty
  a_fetch: assert property (p_fetch)
    else $error("absent boot fetch not errored");
  property p_pulse; boot_fetch_err |=> !boot_fetch_err; endproperty
  a_pulse: assert property (p_pulse)
    else $error("fetch error longer than one cycle");
  property p_ok; boot_fetch_req && boot_present |=> !boot_fetch_err; endproperty
  a_ok: assert property (p_ok)
    else $error("fetch error with boot memory fitted");
  property p_idle; (cnt == 3'h7 && cpu_idle[0]) [*3] |-> !cpu_clk_en[0]; endproperty
  a_idle: assert property (p_idle)
    else $error("idle processor still clocked");
endmodule : rsb_checker
bind rsb_top rsb_checker #(.NUM_CPU(NUM_CPU), .NUM_MAIN(NUM_MAIN)) u_chk (.clk_sys, .rst,
  .cpu_idle, .boot_fetch_req, .main_clk_en, .dbg_clk_en, .cpu_clk_en, .mem_ddr_sel,
  .mem_ratio, .boot_present, .boot_fetch_err, .link_div, .eth_dbg_bus, .eth_dbg_en,
  .cpu_debug, .cpu_run, .cpu0_error);

// File: dv/reset_strap_boot_config_tb_top.sv
`timescale 1ns/1ns
// reset, strap capture and boot checks against a bench model
module reset_strap_boot_config_tb_top;
  import rsb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, debug_unit_enable_strap, debug_break_strap, memory_interface_select_strap;
  logic memory_clock_ratio_strap, boot_memory_present_strap, debug_remote_target_enable_strap;
  logic [7:0] link_clock_divisor_strap, gpio_low, eth_ip_low, link_div;
  logic [3:0] link_remote_target_enable_straps, sw_gate_dbg_set, sw_gate_dbg_clr, cpu_idle;
  logic [3:0] cpu_start, dbg_clk_en, cpu_clk_en, link_rmap_en, cpu_debug, cpu_run;
  logic [1:0] ethernet_debug_bus_select_strap, mem_ratio, eth_dbg_bus, eth_dbg_en;
  logic [15:0] sw_gate_main, main_clk_en;
  logic boot_fetch_req, mem_ddr_sel, boot_present, boot_fetch_err, dbg_rmap_en, cpu0_error;
  logic [31:0] boot_addr;
  rsb_strap_t img;
  logic [15:0] seed = 16'hf77b;
  int err_total = 0;
  int comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  rsb_board u_board (.image(img), .debug_unit_enable_strap, .debug_break_strap,
    .memory_interface_select_strap, .memory_clock_ratio_strap, .boot_memory_present_strap,
    .link_clock_divisor_strap, .link_remote_target_enable_straps,
    .debug_remote_target_enable_strap, .ethernet_debug_bus_select_strap, .gpio_low);
  rsb_top DUT (.clk_sys, .rst, .debug_unit_enable_strap, .debug_break_strap,
    .memory_interface_select_strap, .memory_clock_ratio_strap, .boot_memory_present_strap,
    .link_clock_divisor_strap, .link_remote_target_enable_straps,
    .debug_remote_target_enable_strap, .ethernet_debug_bus_select_strap, .gpio_low,
    .sw_gate_main, .sw_gate_dbg_set, .sw_gate_dbg_clr, .cpu_idle, .boot_fetch_req, .cpu_start,
    .main_clk_en, .dbg_clk_en, .cpu_clk_en, .mem_ddr_sel, .mem_ratio, .boot_present,
    .boot_fetch_err, .link_div, .link_rmap_en, .dbg_rmap_en, .eth_dbg_bus, .eth_dbg_en,
    .eth_ip_low, .cpu_debug, .cpu_run, .cpu0_error, .boot_addr);
  ////////////////////////////////////////////////////////////////////////////
  // lfsr step for random values
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // sample in the middle of a cycle
  task automatic see(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : see
  task automatic test_done;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // one reset with random straps, then boot and gating
  task automatic round(input int k);
    rsb_strap_t e;
    logic [15:0] r;
    logic dbg;
    e = RSB_STRAP_W'({rnd(), rnd()});
    if (k < 4) begin
      e.dbg_en = k[0];
      e.dbg_break = k[1];
    end
    dbg = e.dbg_en & e.dbg_break;
    @(posedge clk_sys);
    rst <= 1'b1;
    img <= e;
    sw_gate_main <= rnd();
    cpu_idle <= 4'hf;
    see(5);
    chk("main_clk_en", 32'hffff, main_clk_en);
    chk("cpu_clk_en", 4'hf, cpu_clk_en);
    @(posedge clk_sys);
    rst <= 1'b0;
    sw_gate_main <= 16'h0;
    cpu_idle <= 4'h0;
    repeat (5) @(posedge clk_sys);
    img <= RSB_STRAP_W'({rnd(), rnd()});
    see(2);
    chk("link_div", e.link_div, link_div);
    chk("link_rmap_en", e.link_rmap, link_rmap_en);
    chk("dbg_rmap_en", e.dbg_rmap, dbg_rmap_en);
    chk("mem_ddr_sel", e.mem_sel, mem_ddr_sel);
    chk("mem_ratio", !e.mem_ratio ? RSB_RATIO_1X : e.mem_sel ? 2 : 1, mem_ratio);
    chk("boot_present", e.boot_present, boot_present);
    chk("eth_ip_low", e.ip_low, eth_ip_low);
    chk("eth_dbg_bus", e.eth_bus & {2{e.dbg_en}}, eth_dbg_bus);
    chk("eth_dbg_en", {2{e.dbg_en}} | (e.eth_bus ^ 2'h3), eth_dbg_en);
    chk("dbg_clk_en", {4{e.dbg_en}}, dbg_clk_en);
    chk("main_clk_en", 32'hffff, main_clk_en);
    chk("cpu_debug", dbg ? 4'hf : 4'h0, cpu_debug);
    chk("cpu_run", dbg ? 4'h0 : 4'h1, cpu_run);
    chk("boot_addr", RSB_BOOT_ADDR, boot_addr);
    if (!dbg) begin
      @(posedge clk_sys);
      boot_fetch_req <= 1'b1;
      @(posedge clk_sys);
      boot_fetch_req <= 1'b0;
      see(1);
      chk("boot_fetch_err", !e.boot_present, boot_fetch_err);
      chk("cpu0_error", !e.boot_present, cpu0_error);
      see(1);
      chk("boot_fetch_err", 0, boot_fetch_err);
    end
    // first processor brought on line by the interrupt controller
    @(posedge clk_sys);
    cpu_start <= 4'h1;
    @(posedge clk_sys);
    cpu_start <= 4'h0;
    see(2);
    chk("cpu_run0", 1, cpu_run[0]);
    chk("cpu0_error", 0, cpu0_error);
    chk("cpu_debug0", 0, cpu_debug[0]);
    @(posedge clk_sys);
    r = rnd();
    sw_gate_main <= r;
    cpu_idle <= r[7:4];
    sw_gate_dbg_set <= 4'h3;
    sw_gate_dbg_clr <= 4'h6;
    @(posedge clk_sys);
    sw_gate_dbg_set <= 4'h0;
    sw_gate_dbg_clr <= 4'h0;
    see(3);
    chk("main_clk_en", r ^ 16'hffff, main_clk_en);
    chk("cpu_clk_en", (r[3:0] | r[7:4]) ^ 4'hf, cpu_clk_en);
    chk("dbg_clk_en", ({4{e.dbg_en}} | 4'h4) & 4'hc, dbg_clk_en);
  endtask : round
  // main sequence
  initial begin
    rst = 1'b1;
    img = '0;
    sw_gate_main = 16'h0;
    sw_gate_dbg_set = 4'h0;
    sw_gate_dbg_clr = 4'h0;
    cpu_idle = 4'h0;
    cpu_start = 4'h0;
    boot_fetch_req = 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int k = 0; k < 10; k++) begin
      round(k);
    end
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
endmodule : reset_strap_boot_config_tb_top
